/* logic/mls_lane_tx.sv */
/*
  One main-link lane transmitter: scrambler, blank start substitution,
  two-entry buffer, 8b/10b encoder and LSB-first serializer.
  Assumes inputs synchronous to ref_clk and a sink that mirrors the LFSR.
*/
`timescale 1ns/1ps
module mls_lane_tx (
  // Clock and reset
  input  wire logic           ref_clk,
  input  wire logic           resetn,
  // Byte stream in
  input  wire logic [7:0]     in_data,
  input  wire logic           in_is_k,
  input  wire logic           in_valid,
  output logic                in_ready,
  // Scrambler control
  input  wire logic           training_active,
  input  wire logic           quality_meas,
  // Lane out
  output logic                ser_bit,
  output logic                ser_valid,
  output logic [9:0]          sym_out,
  output logic                sym_start,
  output logic                reserved_k_error
);
  import mls_pkg::*;

  typedef struct packed {
    logic [15:0]       lfsr;
    logic [8:0]        blank_cnt;
    logic [1:0][7:0]   buf_byte;
    logic [1:0]        buf_k;
    logic              wr_ptr;
    logic              rd_ptr;
    logic [1:0]        count;
    logic              in_ready;
    logic              disp;
    logic [8:0]        shreg;
    logic [3:0]        ser_cnt;
    logic              ser_bit;
    logic              ser_valid;
    logic [9:0]        sym;
    logic              sym_start;
    logic              k_error;
  } mls_state_type;

  mls_state_type st;
  mls_state_type next_st;
  logic          rst_n;
  logic [1:0]    rst_pipe;
  logic          accept;
  logic          k_ok;
  logic          push;
  logic          pop;
  logic [7:0]    push_byte;
  logic          push_k;
  logic          scr_off;
  logic [10:0]   enc;

  // 5b/6b and 3b/4b with running disparity; bit 10 is new disparity
  function automatic logic [10:0] mls_encode(input logic [7:0] b, input logic k,
                                             input logic rd);
    logic [4:0] x;
    logic [2:0] y;
    logic [5:0] c6;
    logic [3:0] c4;
    logic       k28;
    logic       rdm;
    logic       a7;
    logic [9:0] s;
    x   = b[4:0];
    y   = b[7:5];
    k28 = k && (x == 5'h1C);
    c6  = k28 ? MLS_K28_6B : MLS_D6[x];
    if (rd && (k28 || ($countones(c6) != 3) || (x == 5'h07))) begin
      c6 = ~c6;
    end
    rdm = rd ^ ($countones(c6) != 3);
    a7  = (y == 3'h7) && (k || (!rdm && (x == 5'h11 || x == 5'h12 || x == 5'h14))
                            || (rdm && (x == 5'h0B || x == 5'h0D || x == 5'h0E)));
    c4  = a7 ? MLS_A7_4B : MLS_D4[y];
    // Balanced K28 tails flip against the disparity, unlike data tails
    if (rdm ? (a7 || ($countones(c4) != 2) || (y == 3'h3))
            : (k28 && ($countones(c4) == 2) && (y != 3'h3))) begin
      c4 = ~c4;
    end
    for (int i = 0; i < 6; i++) begin
      s[i] = c6[5 - i];
    end
    for (int i = 0; i < 4; i++) begin
      s[6 + i] = c4[3 - i];
    end
    return {rdm ^ ($countones(c4) != 2), s};
  endfunction : mls_encode

  // Reset release through two flops; kept out of the struct, it has its own reset
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe[1];

  always_comb begin
    next_st  = st;
    // off during training and quality measurement
    scr_off  = training_active || quality_meas;
    accept   = in_valid && st.in_ready;
    // only assigned control codes are legal
    k_ok     = (in_data == MLS_BLANK_START) || (in_data == MLS_BLANK_END)
            || (in_data == MLS_SIDE_START)  || (in_data == MLS_SIDE_END)
            || (in_data == MLS_FILL_START)  || (in_data == MLS_FILL_END)
            || (in_data == MLS_SCR_RESET)   || (in_data == MLS_PROT_BLANK)
            || (in_data == MLS_PROT_SCR_RST);
    // reserved special code is dropped and flagged
    push     = accept && (!in_is_k || k_ok);
    push_k   = in_is_k;
    push_byte = in_data;
    next_st.k_error = accept && in_is_k && !k_ok;
    if (push && in_is_k) begin
      if (in_data == MLS_BLANK_START) begin
        if (st.blank_cnt == MLS_BLANK_LAST) begin
          push_byte         = MLS_SCR_RESET;
          next_st.blank_cnt = 9'h000;
        end else begin
          next_st.blank_cnt = st.blank_cnt + 9'h001;
        end
      end
      // reset LFSR on scrambler reset (plain or protected)
      if (push_byte == MLS_SCR_RESET || push_byte == MLS_PROT_SCR_RST) begin
        next_st.lfsr = MLS_LFSR_SEED;
      end
    end else if (push && !scr_off) begin
      // xor with reversed LFSR bits, then step eight places
      for (int i = 0; i < 8; i++) begin
        push_byte[i] = in_data[i] ^ st.lfsr[15 - i];
      end
      next_st.lfsr = mls_lfsr_step(st.lfsr);
    end

    // Serializer: one bit per clock, so the buffer really fills
    pop = (st.count != 2'h0) && (st.ser_cnt <= 4'h1);
    // encoding takes the already scrambled byte
    enc = mls_encode(st.buf_byte[st.rd_ptr], st.buf_k[st.rd_ptr], st.disp);
    next_st.sym_start = pop;
    if (pop) begin
      next_st.sym       = enc[9:0];
      next_st.disp      = enc[10];
      next_st.ser_bit   = enc[0];
      next_st.shreg     = enc[9:1];
      next_st.ser_cnt   = MLS_SYM_BITS;
      next_st.ser_valid = 1'b1;
      next_st.rd_ptr    = ~st.rd_ptr;
    end else if (st.ser_cnt > 4'h1) begin
      next_st.ser_bit   = st.shreg[0];
      next_st.shreg     = {1'b0, st.shreg[8:1]};
      next_st.ser_cnt   = st.ser_cnt - 4'h1;
      next_st.ser_valid = 1'b1;
    end else begin
      next_st.ser_cnt   = 4'h0;
      next_st.ser_valid = 1'b0;
    end

    if (push) begin
      next_st.buf_byte[st.wr_ptr] = push_byte;
      next_st.buf_k[st.wr_ptr]    = push_k;
      next_st.wr_ptr              = ~st.wr_ptr;
    end
    next_st.count    = st.count + {1'b0, push} - {1'b0, pop};
    // Registered ready: full buffer stalls the source
    next_st.in_ready = (next_st.count != 2'h2);
  end

  // reset: LFSR all ones, buffered output bytes zero
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st.lfsr      <= MLS_LFSR_SEED;
      st.blank_cnt <= 9'h000;
      st.buf_byte  <= '0;
      st.buf_k     <= 2'h0;
      st.wr_ptr    <= 1'b0;
      st.rd_ptr    <= 1'b0;
      st.count     <= 2'h0;
      st.in_ready  <= 1'b0;
      st.disp      <= 1'b0;
      st.shreg     <= 9'h000;
      st.ser_cnt   <= 4'h0;
      st.ser_bit   <= 1'b0;
      st.ser_valid <= 1'b0;
      st.sym       <= 10'h000;
      st.sym_start <= 1'b0;
      st.k_error   <= 1'b0;
    end else begin
      st.lfsr      <= next_st.lfsr;
      st.blank_cnt <= next_st.blank_cnt;
      st.buf_byte  <= next_st.buf_byte;
      st.buf_k     <= next_st.buf_k;
      st.wr_ptr    <= next_st.wr_ptr;
      st.rd_ptr    <= next_st.rd_ptr;
      st.count     <= next_st.count;
      st.in_ready  <= next_st.in_ready;
      st.disp      <= next_st.disp;
      st.shreg     <= next_st.shreg;
      st.ser_cnt   <= next_st.ser_cnt;
      st.ser_bit   <= next_st.ser_bit;
      st.ser_valid <= next_st.ser_valid;
      st.sym       <= next_st.sym;
      st.sym_start <= next_st.sym_start;
      st.k_error   <= next_st.k_error;
    end
  end

  assign in_ready         = st.in_ready;
  assign ser_bit          = st.ser_bit;
  assign ser_valid        = st.ser_valid;
  assign sym_out          = st.sym;
  assign sym_start        = st.sym_start;
  assign reserved_k_error = st.k_error;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  lfsr_seed_a: assert property (push && push_k && push_byte == MLS_SCR_RESET
      |=> st.lfsr == 16'hFFFF) else $error("LFSR not reloaded by scrambler reset");
  k_hold_a: assert property (push && push_k && push_byte != MLS_SCR_RESET
      && push_byte != MLS_PROT_SCR_RST |=> $stable(st.lfsr))
      else $error("LFSR moved on a special code");
  data_step_a: assert property (push && !push_k && !scr_off
      |=> st.lfsr == mls_lfsr_step($past(st.lfsr))) else $error("LFSR did not advance");
  scr_off_a: assert property (push && !push_k && scr_off
      |=> $stable(st.lfsr) && st.buf_byte[$past(st.wr_ptr)] == $past(in_data))
      else $error("Data changed while scrambling is off");
  scr_xor_a: assert property (push && !push_k && !scr_off
      |=> st.buf_byte[$past(st.wr_ptr)][0] == ($past(in_data[0]) ^ $past(st.lfsr[15]))
       && st.buf_byte[$past(st.wr_ptr)][7] == ($past(in_data[7]) ^ $past(st.lfsr[8])))
      else $error("Scrambled bit mismatch");
  blank_swap_a: assert property (accept && in_is_k && in_data == MLS_BLANK_START
      && st.blank_cnt == MLS_BLANK_LAST |-> push_byte == MLS_SCR_RESET
      ##1 st.blank_cnt == 9'h000)
      else $error("512th blank start not substituted");
  reserved_drop_a: assert property (accept && in_is_k && !k_ok
      |=> reserved_k_error && st.count == $past(st.count) - {1'b0, $past(pop)})
      else $error("Reserved special code accepted");
  lsb_first_a: assert property (sym_start
      |-> ser_bit == sym_out[0] ##1 ser_bit == $past(sym_out[1]) ##8 ser_bit == sym_out[9])
      else $error("Serial order wrong");
  sym_balance_a: assert property (sym_start
      |-> $countones(sym_out) >= 4 && $countones(sym_out) <= 6)
      else $error("Symbol disparity out of range");
  full_stall_a: assert property (st.count == 2'h2 |-> !in_ready)
      else $error("Ready high while buffer full");

  swap_c: cover property (accept && in_data == MLS_BLANK_START
      && st.blank_cnt == MLS_BLANK_LAST);
  kcode_c: cover property (sym_start && $past(st.buf_k[st.rd_ptr]));
  full_c: cover property (st.count == 2'h2 && in_valid);
  reserved_c: cover property (reserved_k_error);

endmodule : mls_lane_tx

/* logic/mls_pkg.sv */
/*
  Constants, code tables and the LFSR step for one main-link lane transmitter.
  Assumes one bit clock per lane; the sink mirrors the same LFSR decisions.
*/
package mls_pkg;

  localparam logic [15:0] MLS_LFSR_SEED   = 16'hFFFF;
  localparam logic [8:0]  MLS_BLANK_LAST  = 9'h1FF;
  localparam logic [3:0]  MLS_SYM_BITS    = 4'hA;

  // Control symbol byte values (y in bits 7:5, x in bits 4:0)
  localparam logic [7:0] MLS_BLANK_START   = 8'hBC;
  localparam logic [7:0] MLS_BLANK_END     = 8'hFB;
  localparam logic [7:0] MLS_SIDE_START    = 8'h5C;
  localparam logic [7:0] MLS_SIDE_END      = 8'hFD;
  localparam logic [7:0] MLS_FILL_START    = 8'hFE;
  localparam logic [7:0] MLS_FILL_END      = 8'hF7;
  localparam logic [7:0] MLS_SCR_RESET     = 8'h1C;
  localparam logic [7:0] MLS_PROT_BLANK    = 8'h3C;
  localparam logic [7:0] MLS_PROT_SCR_RST  = 8'h7C;

  // 5b/6b codes for running disparity negative, written abcdei
  localparam logic [0:31][5:0] MLS_D6 = {
    6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
    6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17,
    6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A,
    6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};
  localparam logic [5:0] MLS_K28_6B = 6'h0F;
  // 3b/4b codes for running disparity negative, written fghj
  localparam logic [0:7][3:0] MLS_D4 = {
    4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};
  localparam logic [3:0] MLS_A7_4B = 4'h7;

  function automatic logic [15:0] mls_lfsr_step(input logic [15:0] l);
    logic [15:0] n;
    n[0]  = l[15] ^ l[12] ^ l[10] ^ l[9] ^ l[8];
    n[1]  = l[13] ^ l[11] ^ l[10] ^ l[9];
    n[2]  = l[14] ^ l[12] ^ l[11] ^ l[10];
    n[3]  = l[15] ^ l[13] ^ l[12] ^ l[11];
    n[4]  = l[15] ^ l[14] ^ l[13] ^ l[10] ^ l[9] ^ l[8];
    n[5]  = l[15] ^ l[14] ^ l[11] ^ l[10] ^ l[9];
    n[6]  = l[15] ^ l[12] ^ l[11] ^ l[10];
    n[7]  = l[13] ^ l[12] ^ l[11];
    n[8]  = l[14] ^ l[13] ^ l[12] ^ l[0];
    n[9]  = l[15] ^ l[14] ^ l[13] ^ l[1];
    n[10] = l[15] ^ l[14] ^ l[2];
    n[11] = l[15] ^ l[3];
    n[12] = l[4];
    n[13] = l[15] ^ l[12] ^ l[10] ^ l[9] ^ l[8] ^ l[5];
    n[14] = l[13] ^ l[11] ^ l[10] ^ l[9] ^ l[6];
    n[15] = l[15] ^ l[14] ^ l[11] ^ l[9] ^ l[8] ^ l[7];
    return n;
  endfunction : mls_lfsr_step

endpackage : mls_pkg

/* verif/mls_sink_model.sv */
/*
  Sink model for one lane: deserializer, 8b/10b decoder and descrambler.
  Assumes sym_start marks bit 0 of each symbol and scr_off mirrors the source.
*/
`timescale 1ns/1ps
module mls_sink_model
  import mls_pkg::*;
(
  // Lane in
  input  wire logic       ref_clk,
  input  wire logic       ser_bit,
  input  wire logic       ser_valid,
  input  wire logic       sym_start,
  input  wire logic       scr_off,
  // Byte out
  output logic [7:0]      rx_data,
  output logic            rx_is_k,
  output logic            rx_valid
);
  logic [9:0]  sh = 10'h000;
  logic [3:0]  cnt = 4'h0;
  logic [15:0] lfsr = 16'hFFFF;
  initial rx_valid = 1'b0;

  always @(posedge ref_clk) begin : rx
    logic [9:0]  s;
    logic [5:0]  a;
    logic [3:0]  b;
    logic [7:0]  v;
    logic [15:0] l;
    logic        k;
    logic        f;
    rx_valid <= 1'b0;
    if (ser_valid) begin
      // first bit received is bit 0
      s = {ser_bit, sh[9:1]};
      sh <= s;
      cnt <= sym_start ? 4'h1 : cnt + 4'h1;
      if (cnt == 4'h9 && !sym_start) begin
        for (int i = 0; i < 6; i++) a[5-i] = s[i];
        for (int i = 0; i < 4; i++) b[3-i] = s[6+i];
        // both groups decoded; exact code wins over its inverse
        k = (a == MLS_K28_6B) || (a == ~MLS_K28_6B);
        if (a == ~MLS_K28_6B) b = ~b;
        v = {3'h0, k ? 5'h1C : 5'h00};
        for (int i = 31; i >= 0; i--) if (~MLS_D6[i] == a) v[4:0] = i[4:0];
        for (int i = 31; i >= 0; i--) if (MLS_D6[i] == a) v[4:0] = i[4:0];
        for (int i = 7; i >= 0; i--) if (~MLS_D4[i] == b) v[7:5] = i[2:0];
        for (int i = 7; i >= 0; i--) if (MLS_D4[i] == b) v[7:5] = i[2:0];
        if (b == MLS_A7_4B || b == ~MLS_A7_4B) begin
          v[7:5] = 3'h7;
          k = k || (v[4:0] inside {5'h17, 5'h1B, 5'h1D, 5'h1E});
        end
        // descramble after decode; K codes and training bypass
        for (int i = 0; i < 8; i++) if (!k && !scr_off) v[i] = v[i] ^ lfsr[15-i];
        rx_data <= v;
        rx_is_k <= k;
        rx_valid <= 1'b1;
        // same reload, hold and advance as the source
        if (k && (v == MLS_SCR_RESET || v == MLS_PROT_SCR_RST)) begin
          lfsr <= 16'hFFFF;
        end else if (!k && !scr_off) begin
          l = lfsr;
          for (int j = 0; j < 8; j++) begin
            f = l[15];
            l = {l[14:0], f};
            l[4] = l[4] ^ f;
            l[13] = l[13] ^ f;
            l[15] = l[15] ^ f;
          end
          lfsr <= l;
        end
      end
    end
  end
endmodule : mls_sink_model

/* verif/tb_main_link_scramble_encode.sv */
/*
  Testbench for the lane transmitter, judged through a sink model.
  Assumes the design package and the sink model are compiled first.
*/
`timescale 1ns/1ps
module tb_main_link_scramble_encode;
  import mls_pkg::*;
  logic       ref_clk = 1'b0;
  logic       resetn = 1'b0;
  logic [7:0] in_data = 8'h00;
  logic       in_is_k = 1'b0;
  logic       in_valid = 1'b0;
  logic       training_active = 1'b0;
  logic       quality_meas = 1'b0;
  logic       in_ready, ser_bit, ser_valid, sym_start, reserved_k_error;
  logic [9:0] sym_out;
  logic [7:0] rx_data;
  logic       rx_is_k, rx_valid;
  logic [8:0] exp_q[$];
  int         err_count = 0;
  int         comparisons = 0;
  int         blank_cnt = 0;
  logic       full_seen = 1'b0;

  always #2.5 ref_clk = ~ref_clk;

  mls_lane_tx uut (.ref_clk(ref_clk), .resetn(resetn), .in_data(in_data), .in_is_k(in_is_k),
    .in_valid(in_valid), .in_ready(in_ready), .training_active(training_active),
    .quality_meas(quality_meas), .ser_bit(ser_bit), .ser_valid(ser_valid),
    .sym_out(sym_out), .sym_start(sym_start), .reserved_k_error(reserved_k_error));
  mls_sink_model sink (.ref_clk(ref_clk), .ser_bit(ser_bit), .ser_valid(ser_valid),
    .sym_start(sym_start), .scr_off(training_active | quality_meas), .rx_data(rx_data),
    .rx_is_k(rx_is_k), .rx_valid(rx_valid));

  task automatic final_report();
    if (err_count == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : final_report

  task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic tick();
    @(posedge ref_clk);
    #1;
  endtask : tick

  // Every decoded byte must be the next one expected
  always @(posedge ref_clk) if (rx_valid === 1'b1) begin
    if (exp_q.size() == 0) chk("extra symbol", 10'h000, {1'b1, rx_is_k, rx_data});
    else chk("received byte", {1'b0, exp_q.pop_front()}, {1'b0, rx_is_k, rx_data});
  end

  // Every symbol has four to six ones and shows its bit 0 on the lane first
  always @(posedge ref_clk) if (sym_start === 1'b1) begin
    chk("symbol ones", 10'h001, {9'h0, ($countones(sym_out) inside {4, 5, 6})});
    chk("first serial bit", {9'h0, sym_out[0]}, {9'h0, ser_bit});
  end

  // Valid drops for one cycle between requests, so no step assigns it twice
  task automatic send(input logic [7:0] d, input logic k);
    int n;
    logic [7:0] e;
    n = 0;
    e = d;
    tick();
    in_data = d;
    in_is_k = k;
    in_valid = 1'b1;
    while (in_ready !== 1'b1 && n < 100) begin
      full_seen = 1'b1;
      tick();
      n++;
    end
    if (n == 100) begin
      chk("ready wait", 10'h000, 10'h001);
      final_report();
    end
    // every 512th blank start leaves as scrambler reset
    if (k && d == MLS_BLANK_START) blank_cnt++;
    if (blank_cnt == 512) begin
      blank_cnt = 0;
      e = MLS_SCR_RESET;
    end
    if (!k || d inside {MLS_BLANK_START, MLS_BLANK_END, MLS_SIDE_START, MLS_SIDE_END,
        MLS_FILL_START, MLS_FILL_END, MLS_SCR_RESET, MLS_PROT_BLANK, MLS_PROT_SCR_RST})
      exp_q.push_back({k, e});
    tick();
    in_valid = 1'b0;
  endtask : send

  task automatic drain();
    int n;
    n = 0;
    while (exp_q.size() != 0 && n < 400) begin
      tick();
      n++;
    end
    if (n == 400) begin
      chk("drain wait", 10'h000, 10'h001);
      final_report();
    end
    repeat (20) tick();
  endtask : drain

  task automatic t_reset();
    repeat (10) tick();
    chk("reset outputs", 10'h000, {6'h0, in_ready, ser_valid, sym_start, reserved_k_error});
    resetn = 1'b1;
    repeat (4) tick();
  endtask : t_reset

  task automatic t_data();
    full_seen = 1'b0;
    for (int i = 0; i < 40; i++) send(8'(i * 37), 1'b0);
    send(8'hFF, 1'b0);
    drain();
    chk("buffer refused", 10'h001, {9'h0, full_seen});
  endtask : t_data

  task automatic t_codes();
    logic [7:0] kc[9] = '{MLS_BLANK_START, MLS_BLANK_END, MLS_SIDE_START, MLS_SIDE_END,
      MLS_FILL_START, MLS_FILL_END, MLS_SCR_RESET, MLS_PROT_BLANK, MLS_PROT_SCR_RST};
    foreach (kc[i]) begin
      send(kc[i], 1'b1);
      send(8'hA5, 1'b0);
    end
    drain();
  endtask : t_codes

  task automatic t_train();
    training_active = 1'b1;
    repeat (4) send(8'h4A, 1'b0);
    drain();
    training_active = 1'b0;
    quality_meas = 1'b1;
    send(8'hCB, 1'b0);
    drain();
    quality_meas = 1'b0;
    send(8'h4A, 1'b0);
    drain();
  endtask : t_train

  task automatic t_reserved();
    logic [7:0] rc[4] = '{8'h9C, 8'hDC, 8'hFC, 8'h00};
    logic r;
    foreach (rc[i]) begin
      send(rc[i], 1'b1);
      r = reserved_k_error;
      tick();
      r = r | reserved_k_error;
      chk("reserved flag", 10'h001, {9'h0, r});
    end
    send(8'h3D, 1'b0);
    drain();
  endtask : t_reserved

  task automatic t_bs512();
    repeat (600) send(MLS_BLANK_START, 1'b1);
    send(8'h12, 1'b0);
    send(8'h34, 1'b0);
    drain();
  endtask : t_bs512

  initial begin
    t_reset();
    t_data();
    t_codes();
    t_train();
    t_reserved();
    t_bs512();
    final_report();
  end
endmodule : tb_main_link_scramble_encode
